// file: core/embedded_memory_tile.sv
`timescale 1ns/1ps
`include "mem_tile_params.svh"
// What this block does
// - The array holds 4096 bits in every word shape.
// - Content loaded at configuration makes the tile a read-only lookup table.
// - As a lookup table, 8 address bits select any 16-bit result.
// - Words are at most 16 bits wide.
// - Configuration picks single-port or dual-port operation.
// - In dual-port mode write and read sections run at their own rates.
// - Each section has a synchronous enable; disabled, it holds its state.
// - Alternatively input registers use one enable, output registers another.
// - Registers sit on the input signals and on the output data.
// - Dual-port mode serves as FIFO storage on one or two rates.
// - RAM shapes are 256x16, 512x8, 1024x4 and 2048x2.
// - Each of the six tile registers can be bypassed on its own.
// - Tile registers clear asynchronously by local, global or chip reset.
// - The tile makes its own write pulse from the sampled write enable.
module embedded_memory_tile (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clr_local,
    input wire logic clr_global,
    input wire mem_tile_pkg::apb_req_s apb_req,
    output mem_tile_pkg::apb_rsp_s apb_rsp,
    input wire mem_tile_pkg::wr_port_s wr_port,
    input wire mem_tile_pkg::rd_port_s rd_port,
    output logic [15:0] rd_data
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Array kept outside the reset structs: a clear must not wipe
    // loaded content, only the registers around it.
    logic [`TILE_ROW_W-1:0] mem [`TILE_ROWS];

    mem_tile_pkg::cfg_s cfg_reg;
    mem_tile_pkg::cfg_s cfg_next;
    mem_tile_pkg::pipe_s pipe_reg;
    mem_tile_pkg::pipe_s pipe_next;

    logic tile_clr_n;
    logic [10:0] eff_waddr;
    logic [15:0] eff_wdata;
    logic eff_we;
    logic [10:0] eff_raddr;
    logic eff_re;
    logic in_ce;
    logic ra_ce;
    logic out_ce;
    logic [10:0] ra_src;
    logic re_src;
    logic user_write;
    logic load_write;
    logic [7:0] wr_row;
    logic [15:0] wr_row_data;
    logic [15:0] rd_word;
    logic [7:0] rd_row;
    logic apb_setup;
    logic apb_wr;

    // ------------------------------------------------------------
    // Helpers for the word shapes
    // ------------------------------------------------------------
    function automatic logic [7:0] row_of(input logic [10:0] a,
                                          input logic [1:0] s);
        logic [10:0] r;
        r = a >> s;
        return r[7:0];
    endfunction

    function automatic logic [15:0] lane_mask(input logic [1:0] s);
        logic [15:0] m;
        case (s)
            2'h0: m = 16'hFFFF;
            2'h1: m = 16'h00FF;
            2'h2: m = 16'h000F;
            default: m = 16'h0003;
        endcase
        return m;
    endfunction

    function automatic logic [3:0] lane_shift(input logic [10:0] a,
                                              input logic [1:0] s);
        logic [3:0] sh;
        case (s)
            2'h0: sh = 4'h0;
            2'h1: sh = {a[0], 3'h0};
            2'h2: sh = {a[1:0], 2'h0};
            default: sh = {a[2:0], 1'h0};
        endcase
        return sh;
    endfunction

    // ------------------------------------------------------------
    // Clock enable routing
    // ------------------------------------------------------------
    // All sections share clk_sys; each section's rate is its enable.
    always_comb begin
        in_ce = wr_port.ce;
        if (cfg_reg.mode == mem_tile_pkg::MODE_SINGLE) begin
            // One shared access path on the input clock
            ra_src = wr_port.addr;
            re_src = 1'h1;
            ra_ce = wr_port.ce;
            out_ce = cfg_reg.split_io ? rd_port.ce : wr_port.ce;
        end else begin
            ra_src = rd_port.addr;
            re_src = rd_port.en;
            // Input-versus-output arrangement puts the read address
            // on the input enable; otherwise it is read section.
            ra_ce = cfg_reg.split_io ? wr_port.ce : rd_port.ce;
            out_ce = rd_port.ce;
        end
    end

    // ------------------------------------------------------------
    // Register bypass selection
    // ------------------------------------------------------------
    always_comb begin
        eff_waddr = cfg_reg.regen[`REGEN_WADDR] ? pipe_reg.waddr
                                                 : wr_port.addr;
        eff_wdata = cfg_reg.regen[`REGEN_DIN] ? pipe_reg.wdata
                                               : wr_port.data;
        eff_we = cfg_reg.regen[`REGEN_WE] ? pipe_reg.we
                                           : wr_port.en;
        eff_raddr = cfg_reg.regen[`REGEN_RADDR] ? pipe_reg.raddr
                                                 : ra_src;
        eff_re = cfg_reg.regen[`REGEN_RE] ? pipe_reg.re : re_src;
        if (cfg_reg.mode == mem_tile_pkg::MODE_ROM) begin
            // Lookup table: 8 address bits, full 16-bit word
            rd_row = eff_raddr[`LUT_IN_W-1:0];
        end else begin
            rd_row = row_of(eff_raddr, cfg_reg.shape);
        end
        rd_word = (mem[rd_row] >> ((cfg_reg.mode == mem_tile_pkg::MODE_ROM)
                   ? 4'h0 : lane_shift(eff_raddr, cfg_reg.shape)))
                  & ((cfg_reg.mode == mem_tile_pkg::MODE_ROM)
                   ? 16'hFFFF : lane_mask(cfg_reg.shape));
    end

    // ------------------------------------------------------------
    // Write pulse and content load
    // ------------------------------------------------------------
    assign apb_setup = apb_req.psel & ~apb_req.penable;
    assign apb_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    // Content is loaded only in read-only mode, user writes only
    // outside it, so the single write port never sees two writers.
    assign load_write = apb_wr & (apb_req.paddr == `OFS_LOAD_DATA)
                        & (cfg_reg.mode == mem_tile_pkg::MODE_ROM);
    // Internal write strobe from the sampled level on the write edge
    assign user_write = in_ce & eff_we
                        & (cfg_reg.mode != mem_tile_pkg::MODE_ROM);

    always_comb begin
        logic [15:0] m;
        m = lane_mask(cfg_reg.shape) << lane_shift(eff_waddr, cfg_reg.shape);
        if (load_write) begin
            wr_row = cfg_reg.load_ptr;
            wr_row_data = apb_req.pwdata[15:0];
        end else begin
            wr_row = row_of(eff_waddr, cfg_reg.shape);
            wr_row_data = (mem[wr_row] & ~m)
                          | ((eff_wdata
                              << lane_shift(eff_waddr, cfg_reg.shape))
                             & m);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (load_write || user_write) begin
            mem[wr_row] <= wr_row_data;
        end
    end

    // ------------------------------------------------------------
    // Tile registers
    // ------------------------------------------------------------
    // Combined clear; each source is a plain level from outside.
    assign tile_clr_n = rstn & ~clr_local & ~clr_global;

    always_comb begin
        pipe_next = pipe_reg;
        if (in_ce) begin
            pipe_next.waddr = wr_port.addr;
            pipe_next.wdata = wr_port.data;
            pipe_next.we = wr_port.en;
        end
        if (ra_ce) begin
            pipe_next.raddr = ra_src;
            pipe_next.re = re_src;
        end
        // Array is read before this edge's write lands: old word wins
        if (out_ce && eff_re) begin
            pipe_next.dout = rd_word;
        end
    end

    always_ff @(posedge clk_sys or negedge tile_clr_n) begin
        if (!tile_clr_n) begin
            pipe_reg <= '0;
        end else begin
            pipe_reg <= pipe_next;
        end
    end

    // Output register may be bypassed for a flow-through read
    assign rd_data = cfg_reg.regen[`REGEN_DOUT] ? pipe_reg.dout
                                                 : rd_word;

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    always_comb begin
        logic hit;
        logic same_row;
        hit = 1'h0;
        same_row = (wr_row == rd_row);
        cfg_next = cfg_reg;
        // Write and read of one row at one edge; set beats clear
        if (apb_wr && apb_req.paddr == `OFS_STATUS
            && apb_req.pwdata[`STATUS_COLLIDE_BIT]) begin
            cfg_next.collide = 1'h0;
        end
        if (user_write && out_ce && eff_re && same_row) begin
            cfg_next.collide = 1'h1;
        end
        if (apb_wr) begin
            case (apb_req.paddr)
                `OFS_CTRL: begin
                    cfg_next.mode = mem_tile_pkg::mode_e'(
                        apb_req.pwdata[`CTRL_MODE_LSB +: 2]);
                    cfg_next.shape = mem_tile_pkg::shape_e'(
                        apb_req.pwdata[`CTRL_WSEL_LSB +: 2]);
                    cfg_next.split_io =
                        apb_req.pwdata[`CTRL_SPLIT_IO_BIT];
                    cfg_next.regen =
                        apb_req.pwdata[`CTRL_REGEN_LSB +: 6];
                end
                `OFS_LOAD_ADDR: begin
                    cfg_next.load_ptr = apb_req.pwdata[7:0];
                end
                `OFS_LOAD_DATA: begin
                    if (load_write) begin
                        cfg_next.load_ptr = cfg_reg.load_ptr + 8'h01;
                    end
                end
                default: begin
                end
            endcase
        end
        // Read data and error are prepared in the setup cycle
        if (apb_setup) begin
            cfg_next.prdata = 32'h0;
            hit = 1'h1;
            case (apb_req.paddr)
                `OFS_CTRL: begin
                    cfg_next.prdata[`CTRL_MODE_LSB +: 2] = cfg_reg.mode;
                    cfg_next.prdata[`CTRL_WSEL_LSB +: 2] = cfg_reg.shape;
                    cfg_next.prdata[`CTRL_SPLIT_IO_BIT] = cfg_reg.split_io;
                    cfg_next.prdata[`CTRL_REGEN_LSB +: 6] = cfg_reg.regen;
                end
                `OFS_STATUS: begin
                    cfg_next.prdata[15:0] = pipe_reg.dout;
                    cfg_next.prdata[`STATUS_COLLIDE_BIT] = cfg_next.collide;
                end
                `OFS_LOAD_ADDR: begin
                    cfg_next.prdata[7:0] = cfg_reg.load_ptr;
                end
                `OFS_LOAD_DATA: begin
                    cfg_next.prdata[15:0] = mem[cfg_reg.load_ptr];
                end
                default: begin
                    hit = 1'h0;
                end
            endcase
            cfg_next.pslverr = ~hit;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_reg.mode <= mem_tile_pkg::mode_e'(`CTRL_MODE_RST);
            cfg_reg.shape <= mem_tile_pkg::shape_e'(`CTRL_WSEL_RST);
            cfg_reg.split_io <= 1'h0;
            cfg_reg.regen <= `CTRL_REGEN_RST;
            cfg_reg.load_ptr <= 8'h00;
            cfg_reg.collide <= 1'h0;
            cfg_reg.prdata <= 32'h0;
            cfg_reg.pslverr <= 1'h0;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // Zero wait states: every access completes in its first cycle
    always_comb begin
        apb_rsp.pready = 1'h1;
        apb_rsp.pslverr = cfg_reg.pslverr & apb_req.psel & apb_req.penable;
        apb_rsp.prdata = cfg_reg.prdata;
    end

endmodule

// file: core/mem_tile_params.svh
`ifndef MEM_TILE_PARAMS_SVH
`define MEM_TILE_PARAMS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define TILE_BITS 4096
`define TILE_ROWS 256
`define TILE_ROW_W 16
`define TILE_ADDR_W 11
`define LUT_IN_W 8

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_LOAD_ADDR 12'h008
`define OFS_LOAD_DATA 12'h00C

// ----------------------------------------------------------------
// Control and status register fields
// ----------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_WSEL_LSB 2
`define CTRL_SPLIT_IO_BIT 4
`define CTRL_REGEN_LSB 5
`define STATUS_COLLIDE_BIT 16

// Register-enable bit positions inside the regen field
`define REGEN_DIN 0
`define REGEN_DOUT 1
`define REGEN_WADDR 2
`define REGEN_WE 3
`define REGEN_RADDR 4
`define REGEN_RE 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_MODE_RST 2'h1
`define CTRL_WSEL_RST 2'h0
`define CTRL_REGEN_RST 6'h3F

`endif

// file: core/mem_tile_pkg.sv
package mem_tile_pkg;

    // ------------------------------------------------------------
    // Modes and port groups
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_DUAL = 2'h1,
        MODE_ROM = 2'h2,
        MODE_RSVD = 2'h3
    } mode_e;

    // Word shape: 256x16, 512x8, 1024x4, 2048x2
    typedef enum logic [1:0] {
        SHAPE_X16 = 2'h0,
        SHAPE_X8 = 2'h1,
        SHAPE_X4 = 2'h2,
        SHAPE_X2 = 2'h3
    } shape_e;

    typedef struct packed {
        logic ce;
        logic en;
        logic [10:0] addr;
        logic [15:0] data;
    } wr_port_s;

    typedef struct packed {
        logic ce;
        logic en;
        logic [10:0] addr;
    } rd_port_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    // Software-visible configuration and bus state
    typedef struct packed {
        mode_e mode;
        shape_e shape;
        logic split_io;
        logic [5:0] regen;
        logic [7:0] load_ptr;
        logic collide;
        logic [31:0] prdata;
        logic pslverr;
    } cfg_s;

    // Registers wrapped around the array
    typedef struct packed {
        logic [10:0] waddr;
        logic [15:0] wdata;
        logic we;
        logic [10:0] raddr;
        logic re;
        logic [15:0] dout;
    } pipe_s;

endpackage

// file: sim/mem_tile_properties.sv
`timescale 1ns/1ps
module mem_tile_properties (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clr_local,
    input wire logic clr_global,
    input wire mem_tile_pkg::apb_req_s apb_req,
    input wire mem_tile_pkg::apb_rsp_s apb_rsp,
    input wire mem_tile_pkg::wr_port_s wr_port,
    input wire mem_tile_pkg::rd_port_s rd_port,
    input wire logic [15:0] rd_data
);
    // ------------------------------------------------------------
    // Shadow pipeline, trusted only in the reset layout
    // ------------------------------------------------------------
    logic [10:0] ctrl_q;
    logic [7:0] wa_q;
    logic [7:0] ra_q;
    logic [15:0] wd_q;
    logic [15:0] eq_q;
    logic [15:0] mem_q [256];
    logic [255:0] vld_q;
    logic we_q;
    logic re_q;
    logic ok_q;
    logic ev_q;
    logic clr;
    logic dflt;
    logic acc;
    assign clr = clr_local || clr_global;
    assign dflt = ctrl_q == 11'h7E1;
    assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= 11'h7E1;
            we_q <= 1'b0;
            re_q <= 1'b0;
            ok_q <= 1'b1;
            ev_q <= 1'b0;
            vld_q <= '0;
        end else begin
            if (acc && apb_req.pwrite && apb_req.paddr == 12'h000) begin
                ctrl_q <= apb_req.pwdata[10:0];
            end
            if (clr) begin
                we_q <= 1'b0;
                re_q <= 1'b0;
                ev_q <= 1'b0;
            end else begin
                if (wr_port.ce) begin
                    wa_q <= wr_port.addr[7:0];
                    wd_q <= wr_port.data;
                    we_q <= wr_port.en;
                end
                if (rd_port.ce) begin
                    ra_q <= rd_port.addr[7:0];
                    re_q <= rd_port.en;
                end
                if (rd_port.ce && re_q) begin
                    ev_q <= dflt && ok_q && vld_q[ra_q];
                    eq_q <= mem_q[ra_q];
                end
                if (wr_port.ce && we_q && dflt) begin
                    mem_q[wa_q] <= wd_q;
                    vld_q[wa_q] <= 1'b1;
                end
            end
            // Read enable history from other modes is not known
            ok_q <= dflt && (ok_q || rd_port.ce || clr);
            if (!dflt) begin
                vld_q <= '0;
                ev_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    a_rd_hold_idle: assert property (
        dflt && ok_q && !clr && !(rd_port.ce && re_q) ##1 (dflt && !clr)
        |-> $stable(rd_data))
        else $error("read data moved without an enabled read");
    a_rd_data_match: assert property (
        ev_q && dflt && !clr |-> rd_data == eq_q)
        else $error("read data differs from stored word");
    a_clr_zero: assert property (
        ctrl_q[6] && clr |-> rd_data == 16'h0)
        else $error("output register not cleared");
    a_reset_zero: assert property (
        $rose(rstn) |-> rd_data == 16'h0 && apb_rsp.prdata == 32'h0)
        else $error("outputs not zero after reset");
    a_ready_fixed: assert property (
        apb_req.psel |-> apb_rsp.pready)
        else $error("bus wait state inserted");
    a_unmapped_err: assert property (
        acc && apb_req.paddr > 12'h00C |-> apb_rsp.pslverr
        && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (
        acc && apb_req.paddr <= 12'h00C |-> !apb_rsp.pslverr)
        else $error("mapped access refused");
    a_ctrl_readback: assert property (
        acc && !apb_req.pwrite && apb_req.paddr == 12'h000
        |-> apb_rsp.prdata == {21'h0, ctrl_q})
        else $error("control readback wrong");

    c_read_update: cover property (ev_q && dflt);
    c_clear: cover property (clr && ctrl_q[6]);
    c_refused: cover property (acc && apb_rsp.pslverr);
endmodule

bind embedded_memory_tile mem_tile_properties chk_u (
    .clk_sys(clk_sys), .rstn(rstn), .clr_local(clr_local),
    .clr_global(clr_global), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .wr_port(wr_port), .rd_port(rd_port), .rd_data(rd_data)
);

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_sys;
    logic rstn;
    logic clr_local;
    logic clr_global;
    mem_tile_pkg::apb_req_s apb_req;
    mem_tile_pkg::apb_rsp_s apb_rsp;
    mem_tile_pkg::wr_port_s wr_port;
    mem_tile_pkg::rd_port_s rd_port;
    logic [15:0] rd_data;
    logic [15:0] sh [int];
    logic [31:0] rv;
    logic er;
    logic [10:0] a;
    logic [15:0] d;
    int failures;
    int samples_checked;
    int s;

    embedded_memory_tile dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .clr_local(clr_local),
        .clr_global(clr_global), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .wr_port(wr_port), .rd_port(rd_port), .rd_data(rd_data)
    );
    user_logic far_u (
        .clk_sys(clk_sys), .wr_port(wr_port), .rd_port(rd_port)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] mask(input int m);
        return 16'((32'h1 << (16 >> m)) - 1);
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad,
                     pwdata: wd};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (apb_rsp.pready !== 1'b1) begin
            failures++;
            stop_test();
        end
        rv = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // Data for the sampled address shows after the next enabled edge
    task automatic rd(input logic [10:0] ad, input logic [15:0] e);
        far_u.op(1'b0, 1'b1, ad, 16'h0);
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("rd_data", {16'h0, e}, {16'h0, rd_data});
    endtask

    initial begin
        rstn = 1'b0;
        clr_local = 1'b0;
        clr_global = 1'b0;
        apb_req = '0;
        failures = 0;
        samples_checked = 0;
        s = $urandom(64296);
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h7E1, rv);
        apb(1'b0, 12'h010, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            a = (i < 2) ? 11'(255 * i) : 11'($urandom_range(255));
            d = 16'($urandom);
            far_u.op(1'b1, 1'b0, a, d);
            sh[a] = d;
        end
        foreach (sh[k]) begin
            rd(11'(k), sh[k]);
        end
        $display("test dual x16 done");
        d = ~sh[0];
        far_u.op(1'b1, 1'b1, 11'h000, d);
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk("same_row", {16'h0, sh[0]}, {16'h0, rd_data});
        rd(11'h000, d);
        sh[0] = d;
        apb(1'b0, 12'h004, 32'h0);
        chk("status", {15'h0, 1'b1, d}, rv);
        far_u.set_ce(1'b0, 1'b1);
        far_u.op(1'b1, 1'b0, 11'h000, ~d);
        far_u.set_ce(1'b1, 1'b1);
        rd(11'h000, d);
        far_u.set_ce(1'b1, 1'b0);
        far_u.op(1'b0, 1'b1, 11'h0FF, 16'h0);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("rd_hold", {16'h0, d}, {16'h0, rd_data});
        far_u.set_ce(1'b1, 1'b1);
        $display("test enables done");
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, 12'h000, 32'h7E1 | 32'(m << 2));
            sh.delete();
            for (int i = 0; i < 8; i++) begin
                s = (256 << m) - 1;
                a = (i == 0) ? 11'(s) : 11'($urandom_range(s));
                d = 16'($urandom);
                far_u.op(1'b1, 1'b0, a, d);
                sh[a] = d & mask(m);
            end
            foreach (sh[k]) begin
                rd(11'(k), sh[k]);
            end
            $display("test shape %0d done", m);
        end
        apb(1'b1, 12'h000, 32'h7E2);
        apb(1'b1, 12'h008, 32'h0);
        for (int i = 0; i < 256; i++) begin
            sh[i] = 16'($urandom);
            apb(1'b1, 12'h00C, {16'h0, sh[i]});
        end
        far_u.op(1'b1, 1'b0, 11'h005, ~sh[5]);
        for (int i = 0; i < 16; i++) begin
            a = (i == 0) ? 11'h005 : (i == 1) ? 11'h7FF : 11'($urandom);
            rd(a, sh[a[7:0]]);
        end
        apb(1'b1, 12'h008, 32'h5);
        apb(1'b0, 12'h008, 32'h0);
        chk("load_ptr", 32'h5, rv);
        apb(1'b0, 12'h00C, 32'h0);
        chk("load_data", {16'h0, sh[5]}, rv);
        $display("test lookup done");
        apb(1'b1, 12'h000, 32'h7E0);
        d = 16'($urandom);
        far_u.op(1'b1, 1'b0, 11'h021, d);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("single", {16'h0, d}, {16'h0, rd_data});
        sh[33] = d;
        apb(1'b1, 12'h000, 32'h7F1);
        rd(11'h000, sh[0]);
        far_u.set_ce(1'b0, 1'b1);
        far_u.op(1'b0, 1'b1, 11'h021, 16'h0);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("split", {16'h0, sh[0]}, {16'h0, rd_data});
        far_u.set_ce(1'b1, 1'b1);
        rd(11'h021, sh[33]);
        $display("test modes done");
        apb(1'b1, 12'h000, 32'h7E3);
        rd(11'h021, sh[33]);
        // Every tile register bypassed: write and read in one edge
        apb(1'b1, 12'h000, 32'h001);
        d = 16'($urandom);
        far_u.op(1'b1, 1'b1, 11'h040, d);
        @(negedge clk_sys);
        chk("bypass", {16'h0, d}, {16'h0, rd_data});
        apb(1'b1, 12'h004, 32'h10000);
        apb(1'b0, 12'h004, 32'h0);
        chk("collide", 32'h0, {31'h0, rv[16]});
        $display("test bypass done");
        apb(1'b1, 12'h000, 32'h7E1);
        for (int j = 0; j < 2; j++) begin
            @(posedge clk_sys);
            clr_local <= (j == 0);
            clr_global <= (j == 1);
            @(negedge clk_sys);
            chk("cleared", 32'h0, {16'h0, rd_data});
            @(posedge clk_sys);
            clr_local <= 1'b0;
            clr_global <= 1'b0;
            rd(11'h021, sh[33]);
        end
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(negedge clk_sys);
        chk("reset", 32'h0, {16'h0, rd_data});
        @(posedge clk_sys);
        rstn <= 1'b1;
        rd(11'h021, sh[33]);
        $display("test clears done");
        stop_test();
    end
endmodule

// file: sim/user_logic.sv
`timescale 1ns/1ps
module user_logic (
    input wire logic clk_sys,
    output mem_tile_pkg::wr_port_s wr_port,
    output mem_tile_pkg::rd_port_s rd_port
);
    initial begin
        wr_port = '{ce: 1'b1, en: 1'b0, addr: 11'h0, data: 16'h0};
        rd_port = '{ce: 1'b1, en: 1'b0, addr: 11'h0};
    end

    // One write path and one read path; more ports need more tiles
    task automatic op(input logic w, input logic r, input logic [10:0] a,
                      input logic [15:0] d);
        @(posedge clk_sys);
        wr_port.en <= w;
        wr_port.addr <= a;
        wr_port.data <= d;
        rd_port.en <= r;
        rd_port.addr <= a;
        @(posedge clk_sys);
        wr_port.en <= 1'b0;
        rd_port.en <= 1'b0;
        // Data no longer qualified: show a changed pattern
        wr_port.data <= ~d;
    endtask

    // Stalls either section, as slow fabric logic would
    task automatic set_ce(input logic w, input logic r);
        @(posedge clk_sys);
        wr_port.ce <= w;
        rd_port.ce <= r;
    endtask
endmodule
